/* File: verilog/tcb_pkg.sv */
package tcb_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTL = 8'h54;
    localparam logic [7:0] OFS_VAL = 8'h58;
    localparam logic [7:0] OFS_AF0 = 8'h60;
    localparam logic [7:0] OFS_AF1 = 8'h64;
    localparam logic [7:0] OFS_INSEL = 8'h68;
    localparam logic [7:0] OFS_CFG = 8'h6C;
    localparam logic [7:0] OFS_WRITE_PROTECT_LEVEL = 8'h70;

    // field positions
    localparam int CTL_MODE_HI = 16;
    localparam int CTL_CLR = 7;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_SHD = 3;
    localparam int CTL_FAST = 2;
    localparam int VAL_COMB_LO = 29;
    localparam int AF0_ETI_LO = 14;
    localparam int AF_INV = 9;
    localparam int AF_EN = 0;
    localparam int INSEL_CH1_LO = 8;
    localparam int INSEL_CH0_LO = 0;
    localparam int CFG_INPUT = 0;
    localparam int CFG_SPM = 1;
    localparam int WRITE_PROTECT_LEVEL_LVL_LO = 8;
    localparam int WRITE_PROTECT_LEVEL_BRKP = 13;
    localparam int WRITE_PROTECT_LEVEL_DONE = 16;

    // compare mode codes
    localparam logic [3:0] MODE_FROZEN = 4'h0;
    localparam logic [3:0] MODE_SET = 4'h1;
    localparam logic [3:0] MODE_CLR = 4'h2;
    localparam logic [3:0] MODE_TOG = 4'h3;
    localparam logic [3:0] MODE_FLOW = 4'h4;
    localparam logic [3:0] MODE_FHIGH = 4'h5;
    localparam logic [3:0] MODE_PWM0 = 4'h6;
    localparam logic [3:0] MODE_PWM1 = 4'h7;
    localparam logic [3:0] MODE_RSP0 = 4'h8;
    localparam logic [3:0] MODE_RSP1 = 4'h9;

    // trigger sources and input selectors
    localparam logic [3:0] ETI_LEGACY = 4'h0;
    localparam logic [3:0] ETI_WD0 = 4'h3;
    localparam logic [3:0] ETI_WD1 = 4'h4;
    localparam logic [3:0] ETI_WD2 = 4'h5;
    localparam logic [3:0] SEL_PIN = 4'h0;
    localparam logic [3:0] SEL_CMP = 4'h1;

    // write-protect levels
    localparam logic [1:0] LVL_OPEN = 2'h0;
    localparam logic [1:0] LVL_ONE = 2'h1;
    localparam logic [1:0] LVL_THREE = 2'h3;

    localparam logic BRK_EN_RST = 1'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // trigger-to-output latency in clock cycles
    localparam int TRIG_SLOW_CYC = 5;
    localparam int TRIG_FAST_CYC = 3;

    typedef struct packed {
        logic [3:0] mode;
        logic clear_en;
        logic shadow_en;
        logic fast_en;
    } tcb_ch4_cfg_s;

    typedef struct packed {
        logic enable;
        logic invert;
    } tcb_brk_cfg_s;

endpackage

/* File: verilog/tcb_ch4_compare.sv */
// Overview of operation
// - clear enable plus high filtered trigger drives the channel-4 reference low.
// - mode 0 holds, 1 sets, 2 clears, 3 toggles reference on match.
// - mode 4 forces reference low, mode 5 forces it high.
// - pwm0 active below compare up; down inactive above compare, else active.
// - pwm1 inactive below compare up; down active above compare.
// - pwm level changes on entry from any other mode or on comparison change.
// - mode 8 follows pwm0; trigger forces inactive up, active down until update.
// - mode 9 follows pwm1; trigger forces active up, inactive down until update.
// - mode field writes ignored at protect level 11; other codes reserved.
// - with shadow on, value writes land in shadow, copied at update.
// - fast enable in pwm turns a trigger edge into a forced high reference.
// - trigger to output takes 5 cycles, or 3 with fast enable.
// - combine bits AND channel 2,1,0 reference with channel-4 reference.
// - combine bits apply at once unshadowed, else at next update.
// - input mode captures the counter into the value field, read-only.
// - output mode compares the value; shadow loads it each update.
// - trigger source selects legacy pin or watchdogs 0..2; locked at 01.
// - break-0 alternate input used when enabled, inverted before polarity.
// - break-1 alternate input likewise, its level set by break-0 polarity.
// - break enable and invert bits writable only at protect level 00.
// - channel selectors pick capture pin for 0000, comparator for 0001.
// - protect level accepts one write after reset, then stays fixed.
// - break-0 polarity clear means active low, set means active high.
`timescale 1ns/1ps
module tcb_ch4_compare #(
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic count_down,
    input wire logic update_event,
    input wire logic trigger_in,
    input wire logic ext_trigger_filtered,
    input wire logic capture_event,
    input wire logic ch0_ref_in,
    input wire logic ch1_ref_in,
    input wire logic ch2_ref_in,
    input wire logic legacy_trigger_pin,
    input wire logic analog_watchdog0_output,
    input wire logic analog_watchdog1_output,
    input wire logic analog_watchdog2_output,
    input wire logic break0_alt_input,
    input wire logic break1_alt_input,
    input wire logic ch0_capture_pin,
    input wire logic ch1_capture_pin,
    input wire logic comparator0_output,
    input wire logic comparator1_output,
    output logic ch4_output_reference,
    output logic ch0_output_reference,
    output logic ch1_output_reference,
    output logic ch2_output_reference,
    output logic ext_trigger_selected,
    output logic break0_alt_active,
    output logic break1_alt_active,
    output logic ch0_input_routed,
    output logic ch1_input_routed
);

    localparam int PIPE_W = tcb_pkg::TRIG_SLOW_CYC - 1;

    // mode 1 levels are the exact inverse of mode 0 in both directions
    function automatic logic pwm_level(input logic mode1, input logic down,
                                       input logic lt, input logic gt);
        logic lvl0;
        lvl0 = down ? !gt : lt;
        return lvl0 ^ mode1;
    endfunction

    // ---------------- bus slave ----------------
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic word_reg;
    logic [7:0] addr_reg;
    logic [31:0] rd_mux;

    wire addr_ok = hsel && htrans[1] && hready;
    wire wr_go = wr_pend_reg && word_reg;
    wire wr_ctl = wr_go && (addr_reg == tcb_pkg::OFS_CTL);
    wire wr_val = wr_go && (addr_reg == tcb_pkg::OFS_VAL);
    wire wr_af0 = wr_go && (addr_reg == tcb_pkg::OFS_AF0);
    wire wr_af1 = wr_go && (addr_reg == tcb_pkg::OFS_AF1);
    wire wr_insel = wr_go && (addr_reg == tcb_pkg::OFS_INSEL);
    wire wr_cfg = wr_go && (addr_reg == tcb_pkg::OFS_CFG);
    wire wr_write_protect_level = wr_go && (addr_reg == tcb_pkg::OFS_WRITE_PROTECT_LEVEL);

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            word_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            hreadyout <= !(addr_ok && !hwrite);
            hresp <= 1'b0;
            if (addr_ok) begin
                addr_reg <= haddr[7:0];
                word_reg <= (hsize == tcb_pkg::HSIZE_WORD);
            end
            if (rd_pend_reg) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ---------------- registers ----------------
    tcb_pkg::tcb_ch4_cfg_s cfg_reg;
    tcb_pkg::tcb_ch4_cfg_s cfg_next;
    tcb_pkg::tcb_brk_cfg_s brk0_reg;
    tcb_pkg::tcb_brk_cfg_s brk1_reg;
    logic [CNT_W-1:0] val_active_reg;
    logic [CNT_W-1:0] val_shadow_reg;
    logic [2:0] comb_active_reg;
    logic [2:0] comb_pend_reg;
    logic [3:0] eti_sel_reg;
    logic [3:0] insel0_reg;
    logic [3:0] insel1_reg;
    logic input_mode_reg;
    logic spm_reg;
    logic [1:0] write_protect_level_lvl_reg;
    logic write_protect_level_done_reg;
    logic brkp_reg;

    wire lock_mode = write_protect_level_lvl_reg == tcb_pkg::LVL_THREE;
    wire lock_shd = lock_mode && !input_mode_reg;
    wire lock_eti = write_protect_level_lvl_reg == tcb_pkg::LVL_ONE;
    wire lock_brk = write_protect_level_lvl_reg != tcb_pkg::LVL_OPEN;
    wire shd_upd = cfg_reg.shadow_en && update_event;

    // blocked fields simply keep their value, no error answer
    assign cfg_next.mode = (wr_ctl && !lock_mode) ?
        {hwdata[tcb_pkg::CTL_MODE_HI], hwdata[tcb_pkg::CTL_MODE_LO +: 3]}
        : cfg_reg.mode;
    assign cfg_next.clear_en = wr_ctl ? hwdata[tcb_pkg::CTL_CLR]
        : cfg_reg.clear_en;
    assign cfg_next.shadow_en = (wr_ctl && !lock_shd)
        ? hwdata[tcb_pkg::CTL_SHD] : cfg_reg.shadow_en;
    assign cfg_next.fast_en = wr_ctl ? hwdata[tcb_pkg::CTL_FAST]
        : cfg_reg.fast_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val_active_reg <= '0;
            val_shadow_reg <= '0;
            comb_active_reg <= 3'h0;
            comb_pend_reg <= 3'h0;
        end else begin
            if (input_mode_reg && capture_event) begin
                val_active_reg <= counter_value;
            end else if (wr_val && !input_mode_reg && !cfg_reg.shadow_en) begin
                val_active_reg <= hwdata[CNT_W-1:0];
            end else if (shd_upd && !input_mode_reg) begin
                val_active_reg <= val_shadow_reg;
            end
            if (wr_val && !input_mode_reg) begin
                val_shadow_reg <= hwdata[CNT_W-1:0];
            end
            if (wr_val) begin
                comb_pend_reg <= hwdata[tcb_pkg::VAL_COMB_LO +: 3];
            end
            if (wr_val && !cfg_reg.shadow_en) begin
                comb_active_reg <= hwdata[tcb_pkg::VAL_COMB_LO +: 3];
            end else if (shd_upd) begin
                comb_active_reg <= comb_pend_reg;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eti_sel_reg <= tcb_pkg::ETI_LEGACY;
            brk0_reg <= '{enable: tcb_pkg::BRK_EN_RST, invert: 1'b0};
            brk1_reg <= '{enable: tcb_pkg::BRK_EN_RST, invert: 1'b0};
            insel0_reg <= tcb_pkg::SEL_PIN;
            insel1_reg <= tcb_pkg::SEL_PIN;
            input_mode_reg <= 1'b0;
            spm_reg <= 1'b0;
            write_protect_level_lvl_reg <= tcb_pkg::LVL_OPEN;
            write_protect_level_done_reg <= 1'b0;
            brkp_reg <= 1'b0;
        end else begin
            if (wr_af0 && !lock_eti) begin
                eti_sel_reg <= hwdata[tcb_pkg::AF0_ETI_LO +: 4];
            end
            if (wr_af0 && !lock_brk) begin
                brk0_reg.enable <= hwdata[tcb_pkg::AF_EN];
                brk0_reg.invert <= hwdata[tcb_pkg::AF_INV];
            end
            if (wr_af1 && !lock_brk) begin
                brk1_reg.enable <= hwdata[tcb_pkg::AF_EN];
                brk1_reg.invert <= hwdata[tcb_pkg::AF_INV];
            end
            if (wr_insel) begin
                insel0_reg <= hwdata[tcb_pkg::INSEL_CH0_LO +: 4];
                insel1_reg <= hwdata[tcb_pkg::INSEL_CH1_LO +: 4];
            end
            if (wr_cfg) begin
                input_mode_reg <= hwdata[tcb_pkg::CFG_INPUT];
                spm_reg <= hwdata[tcb_pkg::CFG_SPM];
            end
            if (wr_write_protect_level && !write_protect_level_done_reg) begin
                write_protect_level_lvl_reg <= hwdata[tcb_pkg::WRITE_PROTECT_LEVEL_LVL_LO +: 2];
                write_protect_level_done_reg <= 1'b1;
            end
            if (wr_write_protect_level && !lock_brk) begin
                brkp_reg <= hwdata[tcb_pkg::WRITE_PROTECT_LEVEL_BRKP];
            end
        end
    end

    // reserved bits come back as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            tcb_pkg::OFS_CTL: begin
                rd_mux[tcb_pkg::CTL_MODE_HI] = cfg_reg.mode[3];
                rd_mux[tcb_pkg::CTL_CLR] = cfg_reg.clear_en;
                rd_mux[tcb_pkg::CTL_MODE_LO +: 3] = cfg_reg.mode[2:0];
                rd_mux[tcb_pkg::CTL_SHD] = cfg_reg.shadow_en;
                rd_mux[tcb_pkg::CTL_FAST] = cfg_reg.fast_en;
            end
            tcb_pkg::OFS_VAL: begin
                rd_mux[tcb_pkg::VAL_COMB_LO +: 3] = comb_pend_reg;
                rd_mux[CNT_W-1:0] = input_mode_reg ? val_active_reg
                    : val_shadow_reg;
            end
            tcb_pkg::OFS_AF0: begin
                rd_mux[tcb_pkg::AF0_ETI_LO +: 4] = eti_sel_reg;
                rd_mux[tcb_pkg::AF_INV] = brk0_reg.invert;
                rd_mux[tcb_pkg::AF_EN] = brk0_reg.enable;
            end
            tcb_pkg::OFS_AF1: begin
                rd_mux[tcb_pkg::AF_INV] = brk1_reg.invert;
                rd_mux[tcb_pkg::AF_EN] = brk1_reg.enable;
            end
            tcb_pkg::OFS_INSEL: begin
                rd_mux[tcb_pkg::INSEL_CH1_LO +: 4] = insel1_reg;
                rd_mux[tcb_pkg::INSEL_CH0_LO +: 4] = insel0_reg;
            end
            tcb_pkg::OFS_CFG: begin
                rd_mux[tcb_pkg::CFG_INPUT] = input_mode_reg;
                rd_mux[tcb_pkg::CFG_SPM] = spm_reg;
            end
            tcb_pkg::OFS_WRITE_PROTECT_LEVEL: begin
                rd_mux[tcb_pkg::WRITE_PROTECT_LEVEL_LVL_LO +: 2] = write_protect_level_lvl_reg;
                rd_mux[tcb_pkg::WRITE_PROTECT_LEVEL_BRKP] = brkp_reg;
                rd_mux[tcb_pkg::WRITE_PROTECT_LEVEL_DONE] = write_protect_level_done_reg;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ---------------- compare reference ----------------
    logic [PIPE_W-1:0] trig_pipe_reg;
    logic spm_hold_reg;
    logic ref_next;

    // output flop adds the last cycle of each latency
    wire trig_eff = cfg_reg.fast_en
        ? trig_pipe_reg[tcb_pkg::TRIG_FAST_CYC-2]
        : trig_pipe_reg[tcb_pkg::TRIG_SLOW_CYC-2];
    wire match = counter_value == val_active_reg;
    wire cnt_lt = counter_value < val_active_reg;
    wire cnt_gt = counter_value > val_active_reg;
    wire is_rsp = (cfg_reg.mode == tcb_pkg::MODE_RSP0)
        || (cfg_reg.mode == tcb_pkg::MODE_RSP1);
    wire hold_now = spm_hold_reg || trig_eff;
    wire fast_hit = cfg_reg.fast_en && trig_eff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_pipe_reg <= '0;
            spm_hold_reg <= 1'b0;
        end else begin
            trig_pipe_reg <= {trig_pipe_reg[PIPE_W-2:0], trigger_in};
            // a trigger in the update cycle still starts a new pulse
            if (is_rsp && trig_eff) begin
                spm_hold_reg <= 1'b1;
            end else if (update_event || !is_rsp) begin
                spm_hold_reg <= 1'b0;
            end
        end
    end

    // pwm levels follow the comparison each cycle; fast_hit forces them high
    always_comb begin
        ref_next = ch4_output_reference;
        case (cfg_reg.mode)
            tcb_pkg::MODE_FROZEN: ref_next = ch4_output_reference;
            tcb_pkg::MODE_SET: if (match) ref_next = 1'b1;
            tcb_pkg::MODE_CLR: if (match) ref_next = 1'b0;
            tcb_pkg::MODE_TOG: if (match) ref_next = !ch4_output_reference;
            tcb_pkg::MODE_FLOW: ref_next = 1'b0;
            tcb_pkg::MODE_FHIGH: ref_next = 1'b1;
            tcb_pkg::MODE_PWM0: ref_next = fast_hit ? 1'b1
                : pwm_level(1'b0, count_down, cnt_lt, cnt_gt);
            tcb_pkg::MODE_PWM1: ref_next = fast_hit ? 1'b1
                : pwm_level(1'b1, count_down, cnt_lt, cnt_gt);
            tcb_pkg::MODE_RSP0: ref_next = hold_now ? count_down
                : pwm_level(1'b0, count_down, cnt_lt, cnt_gt);
            tcb_pkg::MODE_RSP1: ref_next = hold_now ? !count_down
                : pwm_level(1'b1, count_down, cnt_lt, cnt_gt);
            default: ref_next = ch4_output_reference;
        endcase
        if (cfg_reg.clear_en && ext_trigger_filtered) begin
            ref_next = 1'b0;
        end
    end

    // ---------------- routed outputs ----------------
    wire brk0_lvl = (break0_alt_input ^ brk0_reg.invert) == brkp_reg;
    wire brk1_lvl = (break1_alt_input ^ brk1_reg.invert) == brkp_reg;
    logic eti_mux;

    always_comb begin
        case (eti_sel_reg)
            tcb_pkg::ETI_WD0: eti_mux = analog_watchdog0_output;
            tcb_pkg::ETI_WD1: eti_mux = analog_watchdog1_output;
            tcb_pkg::ETI_WD2: eti_mux = analog_watchdog2_output;
            default: eti_mux = legacy_trigger_pin;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch4_output_reference <= 1'b0;
            ch0_output_reference <= 1'b0;
            ch1_output_reference <= 1'b0;
            ch2_output_reference <= 1'b0;
            ext_trigger_selected <= 1'b0;
            break0_alt_active <= 1'b0;
            break1_alt_active <= 1'b0;
            ch0_input_routed <= 1'b0;
            ch1_input_routed <= 1'b0;
        end else begin
            ch4_output_reference <= ref_next;
            ch0_output_reference <= ch0_ref_in
                && (!comb_active_reg[0] || ch4_output_reference);
            ch1_output_reference <= ch1_ref_in
                && (!comb_active_reg[1] || ch4_output_reference);
            ch2_output_reference <= ch2_ref_in
                && (!comb_active_reg[2] || ch4_output_reference);
            ext_trigger_selected <= eti_mux;
            break0_alt_active <= brk0_reg.enable && brk0_lvl;
            break1_alt_active <= brk1_reg.enable && brk1_lvl;
            ch0_input_routed <= (insel0_reg == tcb_pkg::SEL_CMP)
                ? comparator0_output : ch0_capture_pin;
            ch1_input_routed <= (insel1_reg == tcb_pkg::SEL_CMP)
                ? comparator1_output : ch1_capture_pin;
        end
    end

    // ---------------- checks ----------------
    wire no_clr = !(cfg_reg.clear_en && ext_trigger_filtered);
    wire fast_pwm0 = cfg_reg.fast_en && !cfg_reg.clear_en
        && cfg_reg.mode == tcb_pkg::MODE_PWM0;

    a_clear_ref_low: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_reg.clear_en && ext_trigger_filtered |=> !ch4_output_reference)
        else $error("reference not cleared by trigger input");

    a_frozen_ref_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_reg.mode == tcb_pkg::MODE_FROZEN && no_clr
        |=> $stable(ch4_output_reference))
        else $error("frozen reference moved");

    a_set_on_match: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_reg.mode == tcb_pkg::MODE_SET && match && no_clr
        |=> ch4_output_reference)
        else $error("reference not set on match");

    a_force_levels: assert property (@(posedge hclk) disable iff (!hresetn)
        no_clr && (cfg_reg.mode == tcb_pkg::MODE_FLOW
        || cfg_reg.mode == tcb_pkg::MODE_FHIGH)
        |=> ch4_output_reference == $past(cfg_reg.mode[0]))
        else $error("forced reference level wrong");

    a_fast_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        trigger_in && fast_pwm0 ##1 fast_pwm0 [*2] |=> ch4_output_reference)
        else $error("fast trigger not seen within three cycles");

    a_mode_locked: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctl && write_protect_level_lvl_reg == tcb_pkg::LVL_THREE |=> $stable(cfg_reg.mode))
        else $error("mode written under protect level 11");

    a_shadow_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        shd_upd && !input_mode_reg && !capture_event
        |=> val_active_reg == $past(val_shadow_reg))
        else $error("shadow value not transferred at update");

    a_write_protect_level_once: assert property (@(posedge hclk) disable iff (!hresetn)
        write_protect_level_done_reg |=> $stable(write_protect_level_lvl_reg) && write_protect_level_done_reg)
        else $error("protect level changed after first write");

    a_break_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        write_protect_level_lvl_reg != tcb_pkg::LVL_OPEN |=> $stable(brk0_reg) && $stable(brk1_reg))
        else $error("break bits changed while protected");

    a_break0_level: assert property (@(posedge hclk) disable iff (!hresetn)
        brk0_reg.enable && (break0_alt_input ^ brk0_reg.invert) == brkp_reg
        |=> break0_alt_active)
        else $error("break0 alternate input not active");

endmodule // tcb_ch4_compare

/* File: testbench/tcb_far_model.sv */
`timescale 1ns/1ps
// free-running up counter standing in for the timer core
module tcb_far_model #(
    parameter int PERIOD = 64
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output logic [15:0] counter_value,
    output logic update_event
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_value <= 16'h0000;
            update_event <= 1'b0;
        end else if (run) begin
            update_event <= (counter_value == 16'(PERIOD - 1));
            counter_value <= (counter_value == 16'(PERIOD - 1)) ? 16'h0000
                : counter_value + 16'h0001;
        end else begin
            update_event <= 1'b0;
        end
    end
endmodule // tcb_far_model

/* File: testbench/tcb_ch4_compare_tb.sv */
`timescale 1ns/1ps
module tcb_ch4_compare_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0, etf = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat;
    logic [1:0] htrans = 0, brk = 0;
    logic [2:0] ref_in = 0, chr;
    logic [3:0] src = 0, rs = 0;
    logic [15:0] cnt;
    logic hready, hresp, upd, ch4r, ets, b0a, b1a, r0, r1;
    logic trg = 0;
    int bad_count = 0, compares = 0;
    tcb_far_model far (.hclk(hclk), .hresetn(hresetn), .run(run),
        .counter_value(cnt), .update_event(upd));
    tcb_ch4_compare dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(tcb_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .counter_value(cnt), .count_down(1'b0), .update_event(upd),
        .trigger_in(trg), .ext_trigger_filtered(etf),
        .capture_event(1'b0), .ch0_ref_in(ref_in[0]),
        .ch1_ref_in(ref_in[1]), .ch2_ref_in(ref_in[2]),
        .legacy_trigger_pin(rs[0]), .analog_watchdog0_output(rs[1]),
        .analog_watchdog1_output(rs[2]), .analog_watchdog2_output(rs[3]),
        .break0_alt_input(brk[0]), .break1_alt_input(brk[1]),
        .ch0_capture_pin(src[0]), .ch1_capture_pin(src[1]),
        .comparator0_output(src[2]), .comparator1_output(src[3]),
        .ch4_output_reference(ch4r), .ch0_output_reference(chr[0]),
        .ch1_output_reference(chr[1]), .ch2_output_reference(chr[2]),
        .ext_trigger_selected(ets), .break0_alt_active(b0a),
        .break1_alt_active(b1a), .ch0_input_routed(r0),
        .ch1_input_routed(r1));
    initial forever #25 hclk = ~hclk;
    task stop_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task ck(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        ck(n, e, rdat);
    endtask
    // let registered outputs settle, then look away from the edge
    task wt;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask
    initial begin
        #500000;
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rc("af0", tcb_pkg::OFS_AF0, 32'h1);
        rc("af1", tcb_pkg::OFS_AF1, 32'h1);
        rc("unmapped", 8'h40, 32'h0);
        xf(1'b1, tcb_pkg::OFS_AF1, 32'hFFFFFFFF);
        rc("af1 bits", tcb_pkg::OFS_AF1, 32'h201);
        xf(1'b1, tcb_pkg::OFS_VAL, 32'h20);
        xf(1'b1, tcb_pkg::OFS_CFG, 32'h2);
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h60);
        run <= 1'b1;
        while (cnt !== 16'h10) @(negedge hclk);
        ck("pwm below", 32'h1, {31'h0, ch4r});
        while (cnt !== 16'h30) @(negedge hclk);
        ck("pwm above", 32'h0, {31'h0, ch4r});
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h50);
        wt;
        ck("force high", 32'h1, {31'h0, ch4r});
        xf(1'b1, tcb_pkg::OFS_CTL, 32'hD0);
        etf <= 1'b1;
        wt;
        ck("clear", 32'h0, {31'h0, ch4r});
        @(posedge hclk);
        etf <= 1'b0;
        ref_in <= 3'h7;
        xf(1'b1, tcb_pkg::OFS_VAL, 32'h20000000);
        wt;
        ck("combine hi", 32'h7, {29'h0, chr});
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h40);
        wt;
        ck("combine lo", 32'h6, {29'h0, chr});
        xf(1'b1, tcb_pkg::OFS_INSEL, 32'h1);
        src <= 4'b0110;
        wt;
        ck("route a", 32'h3, {30'h0, r1, r0});
        @(posedge hclk);
        src <= 4'b1001;
        wt;
        ck("route b", 32'h0, {30'h0, r1, r0});
        for (int i = 0; i < 4; i++) begin
            xf(1'b1, tcb_pkg::OFS_AF0, ((i == 0) ? 32'h1 : i + 2) << 14);
            rs <= 4'h1 << i;
            wt;
            ck("trigger sel", 32'h1, {31'h0, ets});
            @(posedge hclk);
            rs <= ~(4'h1 << i);
            wt;
            ck("trigger off", 32'h0, {31'h0, ets});
        end
        xf(1'b1, tcb_pkg::OFS_AF0, 32'h1);
        brk <= 2'b10;
        wt;
        ck("break low", 32'h3, {30'h0, b1a, b0a});
        xf(1'b1, tcb_pkg::OFS_AF0, 32'h201);
        wt;
        ck("break inv", 32'h0, {31'h0, b0a});
        // retriggerable pulse: trigger holds inactive until update
        xf(1'b1, tcb_pkg::OFS_VAL, 32'h30);
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h10000);
        while (cnt !== 16'h08) @(negedge hclk);
        ck("pulse idle", 32'h1, {31'h0, ch4r});
        @(posedge hclk);
        trg <= 1'b1;
        @(posedge hclk);
        trg <= 1'b0;
        while (cnt !== 16'h20) @(negedge hclk);
        ck("pulse held", 32'h0, {31'h0, ch4r});
        while (cnt !== 16'h08) @(negedge hclk);
        ck("pulse freed", 32'h1, {31'h0, ch4r});
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h64);
        while (cnt !== 16'h38) @(negedge hclk);
        ck("fast idle", 32'h0, {31'h0, ch4r});
        @(posedge hclk);
        trg <= 1'b1;
        @(posedge hclk);
        trg <= 1'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        ck("fast hit", 32'h1, {31'h0, ch4r});
        while (cnt !== 16'h10) @(negedge hclk);
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h68);
        xf(1'b1, tcb_pkg::OFS_VAL, 32'h10);
        rc("shadow read", tcb_pkg::OFS_VAL, 32'h10);
        while (cnt !== 16'h20) @(negedge hclk);
        ck("shadow held", 32'h1, {31'h0, ch4r});
        while (cnt !== 16'h08) @(negedge hclk);
        while (cnt !== 16'h20) @(negedge hclk);
        ck("shadow moved", 32'h0, {31'h0, ch4r});
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h40);
        xf(1'b1, tcb_pkg::OFS_WRITE_PROTECT_LEVEL, 32'h300);
        xf(1'b1, tcb_pkg::OFS_CTL, 32'h50);
        xf(1'b1, tcb_pkg::OFS_AF0, 32'h1);
        xf(1'b1, tcb_pkg::OFS_WRITE_PROTECT_LEVEL, 32'h0);
        wt;
        ck("mode locked", 32'h0, {31'h0, ch4r});
        rc("af0 locked", tcb_pkg::OFS_AF0, 32'h201);
        rc("write_protect_level once", tcb_pkg::OFS_WRITE_PROTECT_LEVEL, 32'h10300);
        stop_test;
    end
endmodule // tcb_ch4_compare_tb
